/* src/flash_protect_map.svh */
// offsets, field positions, reset values and opcodes of the write-protect block
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH

// command opcodes seen on the serial link
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROG 8'h12
`define OP_SECTOR_ERASE 8'h21
`define OP_BLOCK_ERASE 8'hdc
`define OP_CHIP_ERASE 8'hc7
`define OP_POWER_DOWN 8'hb9
`define OP_RELEASE_PD 8'hab
`define OP_OTP_ENTER 8'hb1
`define OP_OTP_EXIT 8'hc1
`define OP_SECUR_WRITE 8'h2f
`define OP_SUSPEND 8'hb0
`define OP_RESUME 8'h30
`define OP_SOFT_RESET 8'h99

// least byte counts, opcode included
`define LEN_STATUS 3'd2
`define LEN_ERASE 3'd5
`define LEN_PROG 3'd6

// register offsets on the software port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_SECUR 4'h2
`define REG_REJECT 4'h3
`define REG_COUNT 4'h4

// status byte fields
`define ST_SRWD 7
`define ST_QUAD 6
`define ST_BP_HI 5
`define ST_BP_LO 2
`define ST_LATCH 1

// control and security fields
`define CTL_TB 0
`define CTL_QUAD_PERIPH 1
`define SC_FACTORY 0
`define SC_CUSTOMER 1
`define SC_OTP_MODE 2

// protection geometry
`define BP_ALL 4'hb
`define BLOCK_COUNT 11'h400
`define BLK_HI 25
`define BLK_LO 16
`define OTP_HI 8
`define SERIAL_LAST 9'h00f

// reset values
`define COUNT_RST 8'h00
`define RDATA_RST 8'h00

`endif

/* src/flash_protect_pkg.sv */
// types shared by the write-protect block and its bench
package flash_protect_pkg;

  typedef enum logic {ST_STANDBY, ST_DEEP_PD} pwr_state_type;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_PROGRAM, ACT_ERASE_SECTOR, ACT_ERASE_BLOCK,
    ACT_ERASE_CHIP, ACT_OTP_PROGRAM, ACT_SUSPEND, ACT_RESUME
  } action_type;

  typedef enum logic [2:0] {
    WHY_NONE, WHY_LENGTH, WHY_LATCH, WHY_POWERDOWN, WHY_PROTECT, WHY_OTP, WHY_SHORT
  } reject_type;

  typedef struct packed {
    action_type act;
    logic [31:0] addr;
    logic [7:0] data;
  } commit_type;

  typedef struct packed {
    logic [2:0] bits;
    logic [2:0] bytes;
    logic [6:0] shift;
    logic [7:0] opcode;
    logic [39:0] payload;
  } link_type;

  typedef struct packed {
    pwr_state_type pwr;
    logic latch;
    logic [3:0] bp;
    logic srwd;
    logic quad_en;
    logic tb;
    logic quad_periph;
    logic otp_mode;
    logic cust_lock;
    logic fact_lock;
    logic strap_s1;
    logic strap_s2;
    logic wp_s1;
    logic wp_s2;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic link_clr;
    commit_type commit;
    logic commit_vld;
    logic reject_vld;
    reject_type why;
    logic [7:0] rej_count;
    logic [7:0] rdata;
  } core_type;

endpackage

/* src/flash_write_protect.sv */
// write-protection front end of a serial flash: command capture and filtering
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`include "flash_protect_map.svh"
module flash_write_protect (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic write_protect_pin_n_i,
  input wire logic factory_lock_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output flash_protect_pkg::commit_type commit_o,
  output logic commit_vld_o,
  output logic reject_o
);
  import flash_protect_pkg::*;

  link_type lk;
  link_type next_lk;
  core_type st;
  core_type next_st;
  logic end_pulse;
  logic quad_on;
  logic hw_lock;
  logic pd_ok;

  // block index against the range the level selects
  function automatic logic blk_protected(input logic [9:0] blk, input logic [3:0] bp,
                                         input logic tb);
    logic [10:0] span;
    // bp - 1 wraps for code zero; that case returns before span matters
    span = 11'h001 << (bp - 4'h1);
    if (bp == 4'h0) return 1'b0;
    if (bp >= `BP_ALL) return 1'b1;
    if (tb) return {1'b0, blk} < span;
    return {1'b0, blk} >= (`BLOCK_COUNT - span);
  endfunction

  // status and security data is byte 1 however many extra bytes followed
  function automatic logic [7:0] first_data(input logic [39:0] pl, input logic [2:0] nb);
    logic [7:0] d;
    d = pl[7:0];
    case (nb)
      3'd3: d = pl[15:8];
      3'd4: d = pl[23:16];
      3'd5: d = pl[31:24];
      3'd6: d = pl[39:32];
      default: d = pl[7:0];
    endcase
    return d;
  endfunction

  // link side: shift bits on the rising serial clock
  always_comb begin
    logic [7:0] byte_in;
    byte_in = {lk.shift, si_i};
    next_lk = lk;
    if (!cs_n_i) begin
      next_lk.bits = lk.bits + 3'd1;
      next_lk.shift = byte_in[6:0];
      if (lk.bits == 3'd7) begin
        if (lk.bytes == 3'd0) begin
          next_lk.opcode = byte_in;
        end else if (lk.bytes < `LEN_PROG) begin
          next_lk.payload = {lk.payload[31:0], byte_in};
        end
        // saturate: only opcode, address and first data byte matter
        if (lk.bytes < `LEN_PROG) begin
          next_lk.bytes = lk.bytes + 3'd1;
        end
      end
    end
  end

  // crossing: the core reads the link word only at a frame end, two core
  // cycles after chip select rose, so the word has been still that long
  // and needs no handshake; a host that restarts too soon breaks this
  // cleared from the core once a frame is consumed; serial clock is idle then
  always_ff @(posedge sclk_i or posedge st.link_clr) begin
    if (st.link_clr) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // frame end seen after chip select has passed the synchroniser
  assign end_pulse = st.cs_s2 & ~st.cs_s3;
  // an empty frame (chip select only) is ignored without a reject
  // quad modes reuse the pin as data, so its level means nothing there
  assign quad_on = st.quad_en | st.quad_periph;
  assign hw_lock = st.srwd & ~st.wp_s2 & ~quad_on;
  assign pd_ok = (lk.opcode == `OP_RELEASE_PD) || (lk.opcode == `OP_SUSPEND) ||
                 (lk.opcode == `OP_RESUME) || (lk.opcode == `OP_SOFT_RESET);

  // core side: synchronisers, register port and command filter
  always_comb begin
    reject_type why;
    action_type act;
    logic [31:0] addr;
    logic prot;
    logic [7:0] sdata;
    why = WHY_NONE;
    act = ACT_NONE;
    // with extra bytes the address sits one byte higher in the payload
    addr = (lk.bytes >= `LEN_PROG) ? lk.payload[39:8] : lk.payload[31:0];
    prot = 1'b0;
    sdata = first_data(lk.payload, lk.bytes);
    next_st = st;
    // chip select, protect pin and factory strap pass two flops before the core logic looks at them
    next_st.cs_s1 = cs_n_i;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.wp_s1 = write_protect_pin_n_i;
    next_st.wp_s2 = st.wp_s1;
    next_st.strap_s1 = factory_lock_i;
    next_st.strap_s2 = st.strap_s1;
    next_st.fact_lock = st.fact_lock | st.strap_s2;
    next_st.link_clr = end_pulse;
    next_st.commit_vld = 1'b0;
    next_st.reject_vld = 1'b0;
    next_st.rdata = `RDATA_RST;
    // software port, read data only in the cycle after the strobe
    if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
      next_st.tb = reg_wdata_i[`CTL_TB];
      next_st.quad_periph = reg_wdata_i[`CTL_QUAD_PERIPH];
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL: next_st.rdata = {6'h00, st.quad_periph, st.tb};
        `REG_STATUS: next_st.rdata = {st.srwd, st.quad_en, st.bp, st.latch, 1'b0};
        `REG_SECUR: next_st.rdata = {5'h00, st.otp_mode, st.cust_lock, st.fact_lock};
        `REG_REJECT: next_st.rdata = {5'h00, st.why};
        `REG_COUNT: next_st.rdata = st.rej_count;
        default: next_st.rdata = `RDATA_RST;
      endcase
    end
    // decide only once the whole frame is in; nothing moves mid-frame
    if (end_pulse && (lk.bits != 3'd0 || lk.bytes != 3'd0)) begin
      if (lk.bits != 3'd0) begin
        why = WHY_LENGTH;
      end else if (st.pwr == ST_DEEP_PD && !pd_ok) begin
        why = WHY_POWERDOWN;
      end else begin
        case (lk.opcode)
          `OP_WRITE_ENABLE: next_st.latch = 1'b1;
          `OP_WRITE_DISABLE: next_st.latch = 1'b0;
          `OP_STATUS_WRITE: begin
            if (lk.bytes < `LEN_STATUS) why = WHY_SHORT;
            else if (!st.latch) why = WHY_LATCH;
            else begin
              if (!hw_lock) begin
                next_st.bp = sdata[`ST_BP_HI:`ST_BP_LO];
                next_st.srwd = sdata[`ST_SRWD];
              end
              next_st.quad_en = sdata[`ST_QUAD];
              next_st.latch = 1'b0;
            end
          end
          `OP_SECUR_WRITE: begin
            if (lk.bytes < `LEN_STATUS) why = WHY_SHORT;
            else if (!st.latch) why = WHY_LATCH;
            else begin
              // lock bits are only ever set, never cleared
              // a write without bit 1 leaves the locks as they are
              if (sdata[`SC_CUSTOMER]) next_st.cust_lock = 1'b1;
              next_st.latch = 1'b0;
            end
          end
          `OP_PAGE_PROG: begin
            addr = lk.payload[39:8];
            prot = blk_protected(addr[`BLK_HI:`BLK_LO], st.bp, st.tb);
            if (lk.bytes < `LEN_PROG) why = WHY_SHORT;
            else if (!st.latch) why = WHY_LATCH;
            else if (st.otp_mode) begin
              if (st.fact_lock || st.cust_lock) why = WHY_OTP;
              else if (addr[`OTP_HI:0] <= `SERIAL_LAST) why = WHY_OTP;
              else act = ACT_OTP_PROGRAM;
            end else if (prot) why = WHY_PROTECT;
            else act = ACT_PROGRAM;
          end
          `OP_SECTOR_ERASE, `OP_BLOCK_ERASE: begin
            prot = blk_protected(addr[`BLK_HI:`BLK_LO], st.bp, st.tb);
            if (lk.bytes < `LEN_ERASE) why = WHY_SHORT;
            else if (!st.latch) why = WHY_LATCH;
            else if (st.otp_mode) why = WHY_OTP;
            else if (prot) why = WHY_PROTECT;
            else if (lk.opcode == `OP_SECTOR_ERASE) act = ACT_ERASE_SECTOR;
            else act = ACT_ERASE_BLOCK;
          end
          // any protection at all refuses a whole-chip erase
          `OP_CHIP_ERASE: begin
            if (!st.latch) why = WHY_LATCH;
            else if (st.otp_mode) why = WHY_OTP;
            else if (st.bp != 4'h0) why = WHY_PROTECT;
            else act = ACT_ERASE_CHIP;
          end
          `OP_POWER_DOWN: next_st.pwr = ST_DEEP_PD;
          `OP_RELEASE_PD: next_st.pwr = ST_STANDBY;
          `OP_OTP_ENTER: next_st.otp_mode = 1'b1;
          `OP_OTP_EXIT: next_st.otp_mode = 1'b0;
          `OP_SUSPEND: act = ACT_SUSPEND;
          `OP_RESUME: act = ACT_RESUME;
          `OP_SOFT_RESET: begin
            next_st.pwr = ST_STANDBY;
            next_st.latch = 1'b0;
            next_st.otp_mode = 1'b0;
          end
          default: ; // unknown opcodes are dropped silently
        endcase
      end
      // a finished program or erase consumes the latch
      if (act != ACT_NONE && act != ACT_SUSPEND && act != ACT_RESUME) begin
        next_st.latch = 1'b0;
      end
      next_st.commit.act = act;
      next_st.commit.addr = addr;
      next_st.commit.data = lk.payload[7:0];
      next_st.commit_vld = (act != ACT_NONE);
      next_st.reject_vld = (why != WHY_NONE);
      if (why != WHY_NONE) begin
        next_st.why = why;
        if (st.rej_count != 8'hff) next_st.rej_count = st.rej_count + 8'h01;
      end
    end
    // reset is last so it overrides any decision in the same cycle
    // power-up: standby, latch clear, link cleared while reset holds
    if (!rstn_i) begin
      next_st = '0;
      next_st.cs_s1 = 1'b1;
      next_st.cs_s2 = 1'b1;
      next_st.cs_s3 = 1'b1;
      next_st.wp_s1 = 1'b1;
      next_st.wp_s2 = 1'b1;
      next_st.link_clr = 1'b1;
      next_st.rej_count = `COUNT_RST;
    end
  end

  // core register
  // every field registered on every edge; no enables anywhere
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // outputs straight from flops
  assign reg_rdata_o = st.rdata;
  assign commit_o = st.commit;
  assign commit_vld_o = st.commit_vld;
  assign reject_o = st.reject_vld;

  // checks on the filter
  a_powerup_standby: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(rstn_i) |-> (st.pwr == ST_STANDBY) && !st.latch && !st.otp_mode)
    else $error("not in standby after reset");

  a_length_reject: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits != 3'd0 |=> reject_o && st.why == WHY_LENGTH && !commit_vld_o)
    else $error("partial byte not rejected");

  a_commit_needs_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o && commit_o.act != ACT_SUSPEND && commit_o.act != ACT_RESUME
    |-> $past(st.latch) && !st.latch)
    else $error("write committed without latch");

  a_deep_pd_filter: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && st.pwr == ST_DEEP_PD && !pd_ok |=> !commit_vld_o && $stable(st.pwr))
    else $error("command passed in deep power-down");

  a_protect_array: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o && (commit_o.act == ACT_PROGRAM || commit_o.act == ACT_ERASE_BLOCK ||
    commit_o.act == ACT_ERASE_SECTOR)
    |-> !blk_protected(commit_o.addr[`BLK_HI:`BLK_LO], $past(st.bp), $past(st.tb)))
    else $error("write into protected block");

  a_all_protected: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o && commit_o.act == ACT_ERASE_CHIP |-> $past(st.bp) == 4'h0)
    else $error("chip erase with protection set");

  a_pin_holds_bp: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.opcode == `OP_STATUS_WRITE && hw_lock |=> $stable(st.bp) && $stable(st.srwd))
    else $error("pin protection bypassed");

  a_locks_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(st.cust_lock) || $past(st.fact_lock)
    |-> (st.cust_lock || !$past(st.cust_lock)) && (st.fact_lock || !$past(st.fact_lock)))
    else $error("lock bit cleared");

  a_otp_no_array: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o && $past(st.otp_mode) |-> commit_o.act inside {ACT_OTP_PROGRAM,
    ACT_SUSPEND, ACT_RESUME})
    else $error("array access in one-time mode");

  a_serial_readonly: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o && commit_o.act == ACT_OTP_PROGRAM
    |-> commit_o.addr[`OTP_HI:0] > `SERIAL_LAST && !$past(st.cust_lock) && !$past(st.fact_lock))
    else $error("serial area or locked area programmed");

  a_commit_at_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
    commit_vld_o || reject_o |-> $past(end_pulse) ##1 !commit_vld_o && !reject_o)
    else $error("decision outside frame end");

  // sequencing and sticky state checks
  a_empty_frame: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.bytes == 3'd0 |=> !commit_vld_o && !reject_o)
    else $error("empty frame produced a decision");

  a_status_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && st.pwr == ST_STANDBY && !st.latch &&
    (lk.opcode == `OP_STATUS_WRITE || lk.opcode == `OP_SECUR_WRITE) && lk.bytes >= `LEN_STATUS
    |=> reject_o && st.why == WHY_LATCH)
    else $error("status write without latch not refused");

  a_soft_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.opcode == `OP_SOFT_RESET
    |=> st.pwr == ST_STANDBY && !st.latch && !st.otp_mode)
    else $error("soft reset left state behind");

  a_count_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reject_o |-> st.rej_count == 8'hff || st.rej_count == $past(st.rej_count) + 8'h01)
    else $error("reject count did not step");

  a_factory_seen: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st.strap_s2 |=> st.fact_lock)
    else $error("factory lock not reported");

  a_pd_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.opcode == `OP_POWER_DOWN && st.pwr == ST_STANDBY
    |=> st.pwr == ST_DEEP_PD)
    else $error("power-down not entered");

  a_otp_exit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.opcode == `OP_OTP_EXIT && st.pwr == ST_STANDBY
    |=> !st.otp_mode)
    else $error("one-time mode not left");

  a_short_reject: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.opcode == `OP_PAGE_PROG && lk.bytes < `LEN_PROG &&
    st.pwr == ST_STANDBY |=> reject_o && st.why == WHY_SHORT)
    else $error("short program not refused");

  a_write_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    end_pulse && lk.bits == 3'd0 && lk.opcode == `OP_WRITE_DISABLE && st.pwr == ST_STANDBY
    |=> !st.latch)
    else $error("write disable kept the latch");

  a_bp_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(end_pulse) |-> $stable(st.bp) && $stable(st.srwd))
    else $error("protection bits moved outside a decision");

endmodule

/* tb/spi_host_model.sv */
// behavioural serial host driving the link pins of the write-protect block
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  // link idle: clock low and still, chip select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // mode 0 frame, msb first, 15 ns link clock running only inside the frame
  task automatic frame(input logic [47:0] d, input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = d[47-i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    #7.5 cs_n_o = 1'b1;
    si_o = ~si_o; // released line must not keep showing the last bit
  endtask
endmodule

/* tb/flash_write_protect_tb.sv */
// self-checking bench for the serial flash write-protect block
`timescale 1ns/10ps
`include "flash_protect_map.svh"
module flash_write_protect_tb;
  import flash_protect_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sclk;
  logic cs_n;
  logic si;
  logic pin_n = 1'b1;
  logic fact = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  commit_type commit;
  commit_type last;
  logic cvld;
  logic rej;
  logic [9:0] in_blk;
  logic [9:0] out_blk;
  int sz;
  int fail_count = 0;
  int checked = 0;
  int exp_rej = 0;

  always #25 clk_i = ~clk_i;

  flash_write_protect i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .write_protect_pin_n_i(pin_n), .factory_lock_i(fact), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .commit_o(commit), .commit_vld_o(cvld), .reject_o(rej));
  spi_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  // one place for every comparison
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // register port: one-cycle strobes, read data only in the following cycle
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(name, 32'(rdata), 32'(exp));
  endtask

  // k: 0 no pulse, 1 commit with act code, 2 reject with reason code
  task automatic cmd(input logic [47:0] d, input int n, input int k, input logic [2:0] code);
    logic c;
    logic r;
    c = 1'b0;
    r = 1'b0;
    i_host.frame(d, n);
    // decision lands on the third core clock edge after chip select rises; window also covers the gap
    repeat (10) begin
      @(posedge clk_i);
      #1;
      if (cvld === 1'b1) begin
        c = 1'b1;
        last = commit;
      end
      if (rej === 1'b1) begin
        r = 1'b1;
      end
    end
    chk("commit", 32'(c), 32'(k == 1));
    chk("reject", 32'(r), 32'(k == 2));
    if (k == 1) begin
      chk("act", 32'(last.act), 32'(code));
    end
    if (k == 2) begin
      exp_rej++;
      rchk(`REG_REJECT, {5'h00, code}, "reason");
    end
  endtask

  task automatic write_enable_cmd();
    cmd({`OP_WRITE_ENABLE, 40'h0}, 8, 0, 3'd0);
  endtask

  task automatic prog(input logic [31:0] a, input int k, input logic [2:0] code);
    write_enable_cmd();
    cmd({`OP_PAGE_PROG, a, 8'ha5}, 48, k, code);
  endtask

  task automatic set_bp(input logic [7:0] s);
    write_enable_cmd();
    cmd({`OP_STATUS_WRITE, s, 32'h0}, 16, 0, 3'd0);
  endtask

  task automatic t_reset();
    rchk(`REG_STATUS, 8'h00, "status");
    rchk(`REG_SECUR, 8'h00, "secur");
    rchk(`REG_COUNT, `COUNT_RST, "count");
    reg_wr(`REG_STATUS, 8'hff);
    rchk(`REG_STATUS, 8'h00, "ro status");
    rchk(4'h7, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_latch();
    cmd({`OP_PAGE_PROG, 32'h0000_0100, 8'h5a}, 48, 2, WHY_LATCH);
    write_enable_cmd();
    rchk(`REG_STATUS, 8'h02, "latch set");
    cmd({`OP_PAGE_PROG, 32'h0000_0100, 8'h5a}, 48, 1, ACT_PROGRAM);
    chk("addr", last.addr, 32'h0000_0100);
    chk("data", 32'(last.data), 32'h0000_005a);
    rchk(`REG_STATUS, 8'h00, "latch clear");
    $display("test latch done");
  endtask

  task automatic t_length();
    cmd({`OP_WRITE_ENABLE, 40'h0}, 9, 2, WHY_LENGTH);
    rchk(`REG_STATUS, 8'h00, "no latch");
    write_enable_cmd();
    cmd({`OP_PAGE_PROG, 40'h0}, 47, 2, WHY_LENGTH);
    cmd({`OP_PAGE_PROG, 40'h0}, 40, 2, WHY_SHORT);
    rchk(`REG_STATUS, 8'h02, "latch kept");
    $display("test length done");
  endtask

  // edge blocks of every level, both halves, then the all and none codes
  task automatic t_protect();
    for (int tb = 0; tb < 2; tb++) begin
      reg_wr(`REG_CTRL, 8'(tb));
      for (int n = 1; n < 11; n++) begin
        sz = 1 << (n - 1);
        in_blk = 10'(tb ? sz - 1 : 1024 - sz);
        out_blk = 10'(tb ? sz : 1023 - sz);
        set_bp({2'b00, 4'(n), 2'b00});
        prog({6'h0, in_blk, 16'hfff0}, 2, WHY_PROTECT);
        prog({6'h0, out_blk, 16'h0000}, 1, ACT_PROGRAM);
      end
      for (int c = 11; c < 16; c++) begin
        set_bp({2'b00, 4'(c), 2'b00});
        prog(32'h0000_0000, 2, WHY_PROTECT);
        prog(32'h03ff_ffff, 2, WHY_PROTECT);
      end
    end
    set_bp(8'h00);
    prog(32'h0000_0000, 1, ACT_PROGRAM);
    prog(32'h03ff_0000, 1, ACT_PROGRAM);
    reg_wr(`REG_CTRL, 8'h00);
    $display("test protect done");
  endtask

  task automatic t_pin();
    set_bp(8'h84);
    @(posedge clk_i);
    pin_n <= 1'b0;
    set_bp(8'h88);
    rchk(`REG_STATUS, 8'h84, "bp frozen");
    reg_wr(`REG_CTRL, 8'h02);
    set_bp(8'h08);
    rchk(`REG_STATUS, 8'h08, "bp free in quad");
    reg_wr(`REG_CTRL, 8'h00);
    pin_n <= 1'b1;
    set_bp(8'h00);
    $display("test pin done");
  endtask

  task automatic t_pd();
    cmd({`OP_WRITE_DISABLE, 40'h0}, 8, 0, 3'd0);
    cmd({`OP_POWER_DOWN, 40'h0}, 8, 0, 3'd0);
    cmd({`OP_WRITE_ENABLE, 40'h0}, 8, 2, WHY_POWERDOWN);
    cmd({`OP_SUSPEND, 40'h0}, 8, 1, ACT_SUSPEND);
    cmd({`OP_RESUME, 40'h0}, 8, 1, ACT_RESUME);
    cmd({`OP_RELEASE_PD, 40'h0}, 8, 0, 3'd0);
    write_enable_cmd();
    rchk(`REG_STATUS, 8'h02, "awake");
    $display("test powerdown done");
  endtask

  task automatic t_otp();
    cmd({`OP_OTP_ENTER, 40'h0}, 8, 0, 3'd0);
    rchk(`REG_SECUR, 8'h04, "otp mode");
    write_enable_cmd();
    cmd({`OP_SECTOR_ERASE, 40'h0}, 40, 2, WHY_OTP);
    prog(32'h0000_000f, 2, WHY_OTP);
    prog(32'h0000_0010, 1, ACT_OTP_PROGRAM);
    write_enable_cmd();
    cmd({`OP_SECUR_WRITE, 8'h02, 32'h0}, 16, 0, 3'd0);
    rchk(`REG_SECUR, 8'h06, "customer lock");
    prog(32'h0000_0010, 2, WHY_OTP);
    write_enable_cmd();
    cmd({`OP_SECUR_WRITE, 8'h00, 32'h0}, 16, 0, 3'd0);
    cmd({`OP_OTP_EXIT, 40'h0}, 8, 0, 3'd0);
    rchk(`REG_SECUR, 8'h02, "lock kept");
    prog(32'h0000_0000, 1, ACT_PROGRAM);
    fact <= 1'b1;
    repeat (6) @(posedge clk_i);
    rchk(`REG_SECUR, 8'h03, "factory lock");
    $display("test otp done");
  endtask

  // extra bytes after status write and erase, then the erase and reset opcodes
  task automatic t_extra();
    write_enable_cmd();
    cmd({`OP_STATUS_WRITE, 8'h0c, 32'h1122_3344}, 24, 0, 3'd0);
    rchk(`REG_STATUS, 8'h0c, "extra byte ignored");
    write_enable_cmd();
    cmd({`OP_SECTOR_ERASE, 32'h0012_3000, 8'h77}, 48, 1, ACT_ERASE_SECTOR);
    chk("erase addr", last.addr, 32'h0012_3000);
    write_enable_cmd();
    cmd({`OP_BLOCK_ERASE, 32'h03ff_0000, 8'h00}, 40, 2, WHY_PROTECT);
    cmd({`OP_CHIP_ERASE, 40'h0}, 8, 2, WHY_PROTECT);
    set_bp(8'h00);
    write_enable_cmd();
    cmd({`OP_CHIP_ERASE, 40'h0}, 8, 1, ACT_ERASE_CHIP);
    write_enable_cmd();
    cmd({`OP_SOFT_RESET, 40'h0}, 8, 0, 3'd0);
    rchk(`REG_STATUS, 8'h00, "soft reset");
    $display("test extra done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_reset();
    t_latch();
    t_length();
    t_protect();
    t_pin();
    t_extra();
    t_pd();
    t_otp();
    rchk(`REG_COUNT, 8'(exp_rej), "reject count");
    print_verdict();
  end

  // watchdog well beyond the expected run of a few hundred microseconds
  initial begin
    #3_000_000;
    fail_count++;
    print_verdict();
  end
endmodule
